// *** common/ltg_consts.svh ***
// constants of the low speed tone generator
`ifndef LTG_CONSTS_SVH
`define LTG_CONSTS_SVH
`define LTG_CSR_OFFSET     12'h000
`define LTG_CSR_RESET      8'h1f
`define LTG_DIV_IDLE       5'h1f
`define LTG_SEL_MSB        7
`define LTG_SEL_LSB        6
`define LTG_EN_BIT         5
`define LTG_DIV_MSB        4
`define LTG_DIV_LSB        0
`define LTG_DIV_BIAS       6'h02
`define LTG_SEL_DIV8       2'h0
`define LTG_SEL_DIV4       2'h1
`define LTG_SUB_DIV8       2'h3
`define LTG_SUB_DIV4       2'h1
`define LTG_SUB_DIV2       2'h0
`define LTG_SYS_KHZ        125000
`define LTG_LS_KHZ         128
`endif

// *** common/ltg_pkg.sv ***
// types of the low speed tone generator
package ltg_pkg;
  typedef logic [1:0] ltg_sel_t;
  typedef logic [4:0] ltg_div_t;
endpackage : ltg_pkg

// *** common/ltg_cfg_if.sv ***
// configuration carried from the register file to the tone core
`timescale 1ns/1ns
interface ltg_cfg_if;
  import ltg_pkg::*;
  ltg_sel_t sel;
  logic     en;
  ltg_div_t div;
  logic     ls_tick;
  logic     tone;
  modport regs (output sel, output en, output div, output ls_tick, input tone);
  modport core (input sel, input en, input div, input ls_tick, output tone);
endinterface : ltg_cfg_if

// *** hw/ltg_core.sv ***
// tone divider running on low speed clock ticks
`timescale 1ns/1ns
`include "ltg_consts.svh"
module ltg_core
  import ltg_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  ltg_cfg_if.core   cfg
);
  logic [5:0] pre_r;
  logic [1:0] sub_r;
  logic [1:0] sub_max;
  logic [5:0] pre_max;
  logic       run;
  logic       tone_r;

  // prescaler idles at the reset code and without enable
  assign run     = cfg.en && (cfg.div != `LTG_DIV_IDLE);                  // R3 R7
  assign pre_max = 6'(cfg.div) + `LTG_DIV_BIAS - 6'h01;                  // R8
  always_comb
  begin
    case (cfg.sel)                                                        // R5
      `LTG_SEL_DIV8: sub_max = `LTG_SUB_DIV8;
      `LTG_SEL_DIV4: sub_max = `LTG_SUB_DIV4;
      default:       sub_max = `LTG_SUB_DIV2;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_r  <= '0;
      sub_r  <= '0;
      tone_r <= 1'b0;
    end
    else if (!run)
    begin
      pre_r  <= '0;                                                       // R10
      sub_r  <= '0;
      tone_r <= 1'b0;
    end
    else if (cfg.ls_tick)                                                 // R7
    begin
      if (pre_r >= pre_max)
      begin
        pre_r <= '0;
        if (sub_r >= sub_max)
        begin
          sub_r  <= '0;
          tone_r <= ~tone_r;                                              // R1 R10
        end
        else
          sub_r <= sub_r + 2'h1;
      end
      else
        pre_r <= pre_r + 6'h01;
    end
  end
  assign cfg.tone = tone_r;

  // output stays low whenever the function is off
  property p_off_low;
    @(posedge pclk) disable iff (!presetn) !run |=> !tone_r && pre_r == 6'h00;
  endproperty
  a_off_low: assert property (p_off_low) else $error("tone active while off"); // R10

  property p_idle_code;
    @(posedge pclk) disable iff (!presetn) cfg.div == `LTG_DIV_IDLE |=> pre_r == 6'h00;
  endproperty
  a_idle_code: assert property (p_idle_code) else $error("prescaler ran at idle code"); // R3

  property p_no_tick_hold;
    @(posedge pclk) disable iff (!presetn) run && !cfg.ls_tick |=> $stable(tone_r);
  endproperty
  a_no_tick_hold: assert property (p_no_tick_hold) else $error("tone moved without tick"); // R7

  sequence s_tick_run;
    run && cfg.ls_tick;
  endsequence
  property p_pre_bound;
    @(posedge pclk) disable iff (!presetn)
      s_tick_run ##1 $stable(cfg.div) |-> pre_r <= pre_max;
  endproperty
  a_pre_bound: assert property (p_pre_bound) else $error("prescaler beyond factor"); // R8

  property p_toggle_wrap;
    @(posedge pclk) disable iff (!presetn)
      run && cfg.ls_tick && pre_r >= pre_max && sub_r >= sub_max |=> tone_r != $past(tone_r);
  endproperty
  a_toggle_wrap: assert property (p_toggle_wrap) else $error("tone missed toggle"); // R5

  sequence s_pre_wrap;
    run && cfg.ls_tick && pre_r >= pre_max;
  endsequence
  property p_sub_bound;
    @(posedge pclk) disable iff (!presetn)
      s_pre_wrap ##1 $stable(cfg.sel) |-> sub_r <= sub_max;
  endproperty
  a_sub_bound: assert property (p_sub_bound) else $error("range counter beyond select"); // R1
endmodule : ltg_core

// *** hw/ltg_top.sv ***
// apb register file and low speed tick for the tone generator
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
`include "ltg_consts.svh"
// How it works
// (R1) square tone 1/2/4 kHz from 128 kHz
// (R2) software: divider, then range, then enable
// (R3) prescaler idle while divider equals 0x1F
// (R4) software computes divider from measured clock
// (R5) range select picks /8, /4 or /2
// (R6) bit 5 enables tone, read/write
// (R7) enable gates low speed clock into prescaler
// (R8) division factor equals divider code plus two
// (R9) single register at zero resets 0x1F
// (R10) disabled: output low, prescaler cleared
module ltg_top
  import ltg_pkg::*;
#(
  parameter int SYS_KHZ = `LTG_SYS_KHZ,
  parameter int LS_KHZ  = `LTG_LS_KHZ
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             tone_out
);
  localparam int ACC_W  = 20;
  localparam int GAP_LO = SYS_KHZ / LS_KHZ;
  localparam int GAP_HI = (SYS_KHZ + LS_KHZ - 1) / LS_KHZ;
  logic [7:0]       csr_r;
  logic [ACC_W-1:0] acc_r;
  logic             tick_r;
  logic [ACC_W-1:0] gap_r;
  logic             gap_seen_r;
  logic             hit;
  logic             wr;
  ltg_cfg_if        cfg ();

  // ----------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------
  assign hit     = paddr == `LTG_CSR_OFFSET;                               // R9
  assign wr      = psel && penable && pwrite && hit && pstrb[0];
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      csr_r <= `LTG_CSR_RESET;                                            // R9
    else if (wr)
      csr_r <= pwdata[7:0];                                               // R6
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
      prdata <= hit ? {24'h000000, csr_r} : 32'h00000000;
  end

  // ----------------------------------------
  // low speed clock as fractional tick
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_r  <= '0;
      tick_r <= 1'b0;
    end
    else if (acc_r + ACC_W'(LS_KHZ) >= ACC_W'(SYS_KHZ))
    begin
      acc_r  <= acc_r + ACC_W'(LS_KHZ) - ACC_W'(SYS_KHZ);
      tick_r <= 1'b1;
    end
    else
    begin
      acc_r  <= acc_r + ACC_W'(LS_KHZ);
      tick_r <= 1'b0;
    end
  end

  assign cfg.sel     = csr_r[`LTG_SEL_MSB:`LTG_SEL_LSB];
  assign cfg.en      = csr_r[`LTG_EN_BIT];                                // R6
  assign cfg.div     = csr_r[`LTG_DIV_MSB:`LTG_DIV_LSB];
  assign cfg.ls_tick = tick_r;
  assign tone_out    = cfg.tone;

  ltg_core u_ltg_core (
    .pclk    (pclk),
    .presetn (presetn),
    .cfg     (cfg)
  );

  // ----------------------------------------
  // tick spacing monitor for the checks below
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap_r      <= '0;
      gap_seen_r <= 1'b0;
    end
    else if (tick_r)
    begin
      gap_r      <= ACC_W'(32'h1);
      gap_seen_r <= 1'b1;
    end
    else if (gap_r != '1)
      gap_r <= gap_r + ACC_W'(32'h1);
  end

  // ----------------------------------------
  // register access checks
  // ----------------------------------------
  property p_write_lands;
    @(posedge pclk) disable iff (!presetn) wr |=> csr_r == $past(pwdata[7:0]);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("csr write lost"); // R6

  sequence s_write_miss;
    psel && penable && pwrite && !hit;
  endsequence
  property p_write_miss_kept;
    @(posedge pclk) disable iff (!presetn) s_write_miss |=> $stable(csr_r);
  endproperty
  a_write_miss_kept: assert property (p_write_miss_kept) // R9
    else $error("unmapped write changed csr");

  sequence s_write_masked;
    psel && penable && pwrite && !pstrb[0];
  endsequence
  property p_write_masked;
    @(posedge pclk) disable iff (!presetn) s_write_masked |=> $stable(csr_r);
  endproperty
  a_write_masked: assert property (p_write_masked) // R9
    else $error("write without lane zero changed csr");

  // csr moves only in a write access
  property p_csr_quiet;
    @(posedge pclk) disable iff (!presetn) !(psel && penable && pwrite) |=> $stable(csr_r);
  endproperty
  a_csr_quiet: assert property (p_csr_quiet) // R6
    else $error("csr changed outside a write");

  property p_err_decode;
    @(posedge pclk) disable iff (!presetn) psel && penable |-> pslverr == !hit;
  endproperty
  a_err_decode: assert property (p_err_decode) // R9
    else $error("error response wrong");

  property p_err_idle;
    @(posedge pclk) disable iff (!presetn) !(psel && penable) |-> !pslverr && pready;
  endproperty
  a_err_idle: assert property (p_err_idle) // R9
    else $error("error response outside access");

  sequence s_read_setup;
    psel && !penable && !pwrite && hit;
  endsequence
  property p_read_back;
    @(posedge pclk) disable iff (!presetn) s_read_setup ##1 !wr |-> prdata[7:0] == csr_r;
  endproperty
  a_read_back: assert property (p_read_back) else $error("csr readback wrong"); // R9

  sequence s_read_miss;
    psel && !penable && !pwrite && !hit ##1 psel && penable;
  endsequence
  property p_read_miss_zero;
    @(posedge pclk) disable iff (!presetn) s_read_miss |-> prdata == 32'h00000000;
  endproperty
  a_read_miss_zero: assert property (p_read_miss_zero) // R9
    else $error("unmapped read not zero");

  property p_read_upper_zero;
    @(posedge pclk) disable iff (!presetn) prdata[31:8] == 24'h000000;
  endproperty
  a_read_upper_zero: assert property (p_read_upper_zero) // R9
    else $error("unused read bits not zero");

  // ----------------------------------------
  // low speed tick and tone output checks
  // ----------------------------------------
  property p_tick_pulse;
    @(posedge pclk) disable iff (!presetn) tick_r |=> !tick_r;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) // R1
    else $error("tick longer than one cycle");

  property p_tick_gap;
    @(posedge pclk) disable iff (!presetn)
      tick_r && gap_seen_r |-> gap_r >= ACC_W'(GAP_LO) && gap_r <= ACC_W'(GAP_HI);
  endproperty
  a_tick_gap: assert property (p_tick_gap) // R1
    else $error("tick spacing off the low speed rate");

  property p_tone_off;
    @(posedge pclk) disable iff (!presetn) !csr_r[`LTG_EN_BIT] |=> !tone_out;
  endproperty
  a_tone_off: assert property (p_tone_off) // R7
    else $error("tone high while disabled");

  property p_tone_idle_code;
    @(posedge pclk) disable iff (!presetn)
      csr_r[`LTG_DIV_MSB:`LTG_DIV_LSB] == `LTG_DIV_IDLE |=> !tone_out;
  endproperty
  a_tone_idle_code: assert property (p_tone_idle_code) // R3
    else $error("tone high at idle divider code");

  property p_tone_on_tick;
    @(posedge pclk) disable iff (!presetn) $rose(tone_out) |-> $past(tick_r);
  endproperty
  a_tone_on_tick: assert property (p_tone_on_tick) // R7
    else $error("tone rose without a tick");
endmodule : ltg_top

// *** tb/ltg_buzzer.sv ***
// buzzer model that measures the tone period
`timescale 1ns/1ns
module ltg_buzzer
(
  input  wire logic pclk,
  input  wire logic tone_out,
  output int        period
);
  int   cnt  = 0;
  logic last = 1'b0;
  // full period in pclk cycles between rising edges
  always @(posedge pclk)
  begin
    cnt <= cnt + 1;
    if (tone_out && !last)
    begin
      period <= cnt + 1;
      cnt    <= 0;
    end
    last <= tone_out;
  end
endmodule : ltg_buzzer

// *** tb/test_low_speed_tone_generator.sv ***
// self-checking bench of the tone generator
`timescale 1ns/1ns
module test_low_speed_tone_generator;
  localparam int LSK = 12500;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, tone_out;
  logic [31:0] lfsr = 32'he902502f;
  int          fail_count = 0, n_compared = 0, cyc = 0, period, csr_m, dv;
  int          f_hz, a_int, code, model_csr = 32'h1f;
  int          exp_q[$];
  ltg_top #(.LS_KHZ(LSK)) u_ltg_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tone_out(tone_out));
  ltg_buzzer u_ltg_buzzer (.pclk(pclk), .tone_out(tone_out), .period(period));
  always #4 pclk = ~pclk;
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    if (!w)
      exp_q.push_back(a == 12'h000 ? model_csr : 0);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, err}, {31'h0, a != 12'h000});
    if (!w)
      chk(rd, 32'(exp_q.pop_front()));
    else if (a == 12'h000 && s[0])
      model_csr = int'(d[7:0]);
  endtask : apb
  task end_sim;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      fail_count++;
      end_sim();
    end
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0, 4'hf);
    chk(rd, 32'h1f);
    chk({31'h0, tone_out}, 0);
    chk({31'h0, pready}, 1);
    apb(1, 12'h000, 32'h3f, 4'hf);
    repeat (2000) @(posedge pclk);
    chk(32'(period), 0);
    apb(1, 12'h004, 32'h25, 4'hf);
    chk({31'h0, err}, 1);
    apb(0, 12'h004, 0, 4'hf);
    chk(rd, 0);
    apb(1, 12'h000, 32'h00, 4'he);
    apb(0, 12'h000, 0, 4'hf);
    chk(rd, 32'h3f);
    for (int s = 0; s < 4; s++)
    begin
      lfsr = lfsr_next(lfsr);
      dv = int'(lfsr % 31);
      csr_m = (s << 6) | 32 | dv;
      apb(1, 12'h000, 32'(dv), 4'hf);
      apb(1, 12'h000, 32'(csr_m & 32'hdf), 4'hf);
      apb(1, 12'h000, 32'(csr_m), 4'hf);
      apb(0, 12'h000, 0, 4'hf);
      chk(rd, 32'(csr_m));
      repeat (3) @(posedge tone_out);
      repeat (2) @(posedge pclk);
      chk(32'(period), 32'(2 * (dv + 2) * (s == 0 ? 4 : s == 1 ? 2 : 1) * 125000 / LSK));
    end
    // calibration from a measured low speed clock in Hz
    lfsr = lfsr_next(lfsr);
    f_hz = 112000 + int'(lfsr % 32001);
    a_int = f_hz / 8000;
    code = (f_hz % 8000) * (1 + 2 * a_int) <= a_int * 8000 ? a_int - 2 : a_int - 1;
    csr_m = 32 | code;
    apb(1, 12'h000, 32'(code), 4'hf);
    apb(1, 12'h000, 32'(code), 4'hf);
    apb(1, 12'h000, 32'(csr_m), 4'hf);
    repeat (3) @(posedge tone_out);
    repeat (2) @(posedge pclk);
    chk(32'(period), 32'(2 * (code + 2) * 4 * 125000 / LSK));
    @(posedge tone_out);
    apb(1, 12'h000, 32'(csr_m & 32'hdf), 4'hf);
    repeat (4) @(posedge pclk);
    chk({31'h0, tone_out}, 0);
    // reset in mid-run while the tone is high
    apb(1, 12'h000, 32'(csr_m), 4'hf);
    @(posedge tone_out);
    presetn <= 1'b0;
    model_csr = 32'h1f;
    repeat (3) @(posedge pclk);
    chk({31'h0, tone_out}, 0);
    presetn <= 1'b1;
    apb(0, 12'h000, 0, 4'hf);
    chk(rd, 32'h1f);
    end_sim();
  end
endmodule : test_low_speed_tone_generator
